//--- common/ccr_cfg_if.sv
`timescale 1ns/100ps
interface ccr_cfg_if;
    logic [7:0] sys_ctl;
    logic [7:0] cur_ctl;
    logic [7:0] pre_term;
    logic ce_n_s;
    logic [4:0] iin_code;
    logic charge_run;
    logic switch_low;
    logic [5:0] fast_charge_current_code_eff;
    logic [3:0] pre_eff;
    modport regs (output sys_ctl, cur_ctl, pre_term, ce_n_s, iin_code,
                  input charge_run, switch_low, fast_charge_current_code_eff, pre_eff);
    modport dec (input sys_ctl, cur_ctl, pre_term, ce_n_s, iin_code,
                 output charge_run, switch_low, fast_charge_current_code_eff, pre_eff);
endinterface

//--- common/ccr_params.svh
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
// serial slave address and register offsets
`define CCR_DEV_ADDR 7'h6B
`define CCR_OFS_SYS 8'h01
`define CCR_OFS_CUR 8'h02
`define CCR_OFS_PRE 8'h03
// reset values
`define CCR_RST_SYS 8'h1A
`define CCR_RST_CUR 8'hA2
`define CCR_RST_PRE 8'h22
// bits that survive watchdog expiry
`define CCR_WDK_SYS 8'h8F
`define CCR_WDK_CUR 8'h40
`define CCR_WDK_PRE 8'h00
// field positions
`define CCR_BIT_PSKIP 7
`define CCR_BIT_KICK 6
`define CCR_BIT_BOOST 5
`define CCR_BIT_CHG 4
`define CCR_FLOOR_HI 3
`define CCR_FLOOR_LO 1
`define CCR_BIT_VBSEL 0
`define CCR_BIT_BLIM 7
`define CCR_BIT_FULL 6
`define CCR_FAST_CHARGE_CURRENT_CODE_HI 5
`define CCR_PRE_HI 7
`define CCR_PRE_LO 4
`define CCR_TERM_HI 3
// code limits
`define CCR_FAST_CHARGE_CURRENT_CODE_MAX 6'h32
`define CCR_IPRE_MAX 4'hC
`define CCR_IIN_700MA 5'h06
`define CCR_RD_FILL 8'h00
`endif

//--- common/ccr_pkg.sv
package ccr_pkg;
    typedef enum logic [3:0] {
        CCR_IDLE,
        CCR_ADDR,
        CCR_ADDR_ACK,
        CCR_PTR,
        CCR_PTR_ACK,
        CCR_WDATA,
        CCR_WDATA_ACK,
        CCR_RDATA,
        CCR_RDATA_ACK
    } ccr_i2c_state_t;
endpackage

//--- logic/ccr_charger_regs.sv
`timescale 1ns/100ps
`include "ccr_params.svh"
// Overview of operation
// R1 - System control register resets to 00011010.
// R2 - Bit 7 set forces light-load pulse skipping off; clear keeps it on.
// R3 - Writing 1 to bit 6 kicks the watchdog; the bit then clears itself.
// R4 - Boost enable overrides charge enable; no charging while boost is on.
// R5 - Charging needs charge-enable pin low and charge enable bit set together.
// R6 - Three-bit system floor field codes 2.6 V to 3.7 V, reset 101.
// R7 - Bit 0 picks boost falling battery threshold 2.8 V or 2.5 V.
// R8 - Current control register resets to 10100010.
// R9 - Bit 7 picks boost current limit 0.5 A or 1.2 A.
// R10 - Sizing bit clear uses small switch below 700 mA input limit.
// R11 - In boost the full input switch is always used.
// R12 - Fast-charge code is binary, 60 mA per step, no offset.
// R13 - Fast-charge code zero disables charging.
// R14 - Fast-charge codes above 110010 act as 110010.
// R15 - Third register resets to 00100010: precharge high nibble, termination low.
// R16 - Precharge and termination codes 60 mA offset plus 60 mA steps; precharge clamps at 1100.
// R17 - Watchdog expiry restores defaults except skip, floor, threshold and sizing bits.
module ccr_charger_regs
    import ccr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic charge_enable_n,
    input wire logic reg_reset,
    input wire logic watchdog_expired,
    input wire logic [4:0] input_current_limit_code,
    output logic pulse_skip_disable,
    output logic watchdog_kick,
    output logic boost_enable,
    output logic charge_allowed,
    output logic [2:0] system_floor_voltage,
    output logic boost_floor_low_sel,
    output logic boost_current_limit,
    output logic input_switch_full_size,
    output logic [5:0] fast_charge_current_code,
    output logic [3:0] precharge_current_code,
    output logic [3:0] termination_current_code
);
    ccr_cfg_if cfg();
    ccr_i2c_state_t state;
    logic scl_s;
    logic sda_s;
    logic ce_n_s;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [2:0] bit_cnt;
    logic got_byte;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic wr_stb;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] sys_ctl;
    logic [7:0] cur_ctl;
    logic [7:0] pre_term;
    logic kick_q;
    logic sda_low;
    logic [7:0] rd_next;

    function automatic logic idx_ok(input logic [7:0] idx);
        idx_ok = (idx == `CCR_OFS_SYS) || (idx == `CCR_OFS_CUR) || (idx == `CCR_OFS_PRE);
    endfunction

    function automatic logic [7:0] rd_byte(input logic [7:0] idx, input logic [7:0] r1,
                                           input logic [7:0] r2, input logic [7:0] r3);
        case (idx)
            `CCR_OFS_SYS: rd_byte = r1;
            `CCR_OFS_CUR: rd_byte = r2;
            `CCR_OFS_PRE: rd_byte = r3;
            default: rd_byte = `CCR_RD_FILL;
        endcase
    endfunction

    ccr_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({scl_in, sda_in, charge_enable_n}),
        .sync_out({scl_s, sda_s, ce_n_s})
    );

    ccr_field_decode u_dec (
        .sys_clk(sys_clk),
        .rst(rst),
        .cfg(cfg.dec)
    );

    assign cfg.sys_ctl = sys_ctl;
    assign cfg.cur_ctl = cur_ctl;
    assign cfg.pre_term = pre_term;
    assign cfg.ce_n_s = ce_n_s;
    assign cfg.iin_code = input_current_limit_code;
    assign rd_next = rd_byte(ptr, sys_ctl, cur_ctl, pre_term);

    // edge detection on the synchronised bus lines
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign bus_start = scl_s && scl_d && sda_d && !sda_s;
    assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

    // serial slave: address, pointer, then data with auto-increment
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= CCR_IDLE;
            bit_cnt <= 3'h0;
            got_byte <= 1'b0;
            shreg <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_idx <= 8'h00;
            wr_data <= 8'h00;
        end
        else
        begin
            wr_stb <= 1'b0;
            if (bus_start)
            begin
                state <= CCR_ADDR;
                bit_cnt <= 3'h0;
                got_byte <= 1'b0;
                sda_oe <= 1'b0;
            end
            else if (bus_stop)
            begin
                state <= CCR_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state)
                    CCR_ADDR, CCR_PTR, CCR_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shreg <= {shreg[6:0], sda_s};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7)
                            begin
                                got_byte <= 1'b1;
                            end
                        end
                        else if (scl_fall && got_byte)
                        begin
                            got_byte <= 1'b0;
                            if (state == CCR_ADDR)
                            begin
                                if (shreg[7:1] == `CCR_DEV_ADDR && (!shreg[0] || idx_ok(ptr)))
                                begin
                                    sda_oe <= 1'b1;
                                    state <= CCR_ADDR_ACK;
                                    tx <= rd_byte(ptr, sys_ctl, cur_ctl, pre_term);
                                end
                                else
                                begin
                                    state <= CCR_IDLE;
                                end
                            end
                            else if (idx_ok(state == CCR_PTR ? shreg : ptr))
                            begin
                                sda_oe <= 1'b1;
                                if (state == CCR_PTR)
                                begin
                                    ptr <= shreg;
                                    state <= CCR_PTR_ACK;
                                end
                                else
                                begin
                                    wr_stb <= 1'b1;
                                    wr_idx <= ptr;
                                    wr_data <= shreg;
                                    ptr <= ptr + 8'h01;
                                    state <= CCR_WDATA_ACK;
                                end
                            end
                            else
                            begin
                                // unmapped pointer: no acknowledge, back to idle
                                state <= CCR_IDLE;
                            end
                        end
                    end
                    CCR_ADDR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (shreg[0])
                            begin
                                sda_oe <= !tx[7];
                                tx <= {tx[6:0], 1'b0};
                                bit_cnt <= 3'h1;
                                state <= CCR_RDATA;
                            end
                            else
                            begin
                                sda_oe <= 1'b0;
                                state <= CCR_PTR;
                            end
                        end
                    end
                    CCR_PTR_ACK, CCR_WDATA_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b0;
                            state <= CCR_WDATA;
                        end
                    end
                    CCR_RDATA:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt == 3'h0)
                            begin
                                sda_oe <= 1'b0;
                                state <= CCR_RDATA_ACK;
                            end
                            else
                            begin
                                sda_oe <= !tx[7];
                                tx <= {tx[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 3'h1;
                            end
                        end
                    end
                    CCR_RDATA_ACK:
                    begin
                        if (scl_rise)
                        begin
                            if (sda_s)
                            begin
                                state <= CCR_IDLE;
                            end
                            else
                            begin
                                ptr <= ptr + 8'h01;
                                got_byte <= 1'b1;
                            end
                        end
                        else if (scl_fall && got_byte)
                        begin
                            got_byte <= 1'b0;
                            tx <= {rd_next[6:0], 1'b0};
                            sda_oe <= !rd_next[7];
                            bit_cnt <= 3'h1;
                            state <= CCR_RDATA;
                        end
                        else if (!got_byte && scl_fall)
                        begin
                            state <= CCR_IDLE;
                        end
                    end
                    default:
                    begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // register bank; a host write in the same cycle wins over self-clear
    always_ff @(posedge sys_clk)
    begin
        if (rst || reg_reset)
        begin
            sys_ctl <= `CCR_RST_SYS; // R1 R6
            cur_ctl <= `CCR_RST_CUR; // R8
            pre_term <= `CCR_RST_PRE; // R15
        end
        else
        begin
            if (watchdog_expired)
            begin
                sys_ctl <= (sys_ctl & `CCR_WDK_SYS) | (`CCR_RST_SYS & ~`CCR_WDK_SYS); // R17
                cur_ctl <= (cur_ctl & `CCR_WDK_CUR) | (`CCR_RST_CUR & ~`CCR_WDK_CUR); // R17
                pre_term <= (pre_term & `CCR_WDK_PRE) | (`CCR_RST_PRE & ~`CCR_WDK_PRE); // R17
            end
            else if (sys_ctl[`CCR_BIT_KICK])
            begin
                sys_ctl[`CCR_BIT_KICK] <= 1'b0; // R3
            end
            if (wr_stb)
            begin
                case (wr_idx)
                    `CCR_OFS_SYS: sys_ctl <= wr_data;
                    `CCR_OFS_CUR: cur_ctl <= wr_data;
                    `CCR_OFS_PRE: pre_term <= wr_data;
                    default: ;
                endcase
            end
        end
    end

    // watchdog restart pulse follows the kick bit by one cycle
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            kick_q <= 1'b0;
            sda_low <= 1'b0;
        end
        else
        begin
            kick_q <= sys_ctl[`CCR_BIT_KICK]; // R3
            sda_low <= 1'b0;
        end
    end

    assign sda_out = sda_low;
    assign watchdog_kick = kick_q;
    assign pulse_skip_disable = sys_ctl[`CCR_BIT_PSKIP]; // R2
    assign boost_enable = sys_ctl[`CCR_BIT_BOOST]; // R4
    assign system_floor_voltage = sys_ctl[`CCR_FLOOR_HI:`CCR_FLOOR_LO]; // R6
    assign boost_floor_low_sel = sys_ctl[`CCR_BIT_VBSEL]; // R7
    assign boost_current_limit = cur_ctl[`CCR_BIT_BLIM]; // R9
    assign charge_allowed = cfg.charge_run;
    assign input_switch_full_size = cfg.switch_low;
    assign fast_charge_current_code = cfg.fast_charge_current_code_eff; // R12
    assign precharge_current_code = cfg.pre_eff;
    assign termination_current_code = pre_term[`CCR_TERM_HI:0]; // R16

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_sys_reset_value: assert property ($past(rst) |-> sys_ctl == `CCR_RST_SYS) // R1
        else $error("system control not at reset value");
    a_cur_reset_value: assert property ($past(rst) |-> cur_ctl == `CCR_RST_CUR) // R8
        else $error("current control not at reset value");
    a_pre_reset_value: assert property ($past(rst) |-> pre_term == `CCR_RST_PRE) // R15
        else $error("precharge register not at reset value");
    a_kick_self_clear: assert property ( // R3
        wr_stb && wr_idx == `CCR_OFS_SYS && wr_data[`CCR_BIT_KICK] && !watchdog_expired
        && !reg_reset |=> sys_ctl[`CCR_BIT_KICK] ##1 (!sys_ctl[`CCR_BIT_KICK] && watchdog_kick))
        else $error("watchdog kick bit did not pulse and clear");
    a_boost_no_charge: assert property ($past(sys_ctl[`CCR_BIT_BOOST]) |-> !charge_allowed) // R4
        else $error("charging while boost enabled");
    a_charge_gate: assert property (charge_allowed |-> $past(!ce_n_s && // R5
        sys_ctl[`CCR_BIT_CHG] && cur_ctl[`CCR_FAST_CHARGE_CURRENT_CODE_HI:0] != 6'h00)) // R13
        else $error("charge allowed without enables");
    a_fast_charge_current_code_clamp: assert property ( // R14
        $past(cur_ctl[`CCR_FAST_CHARGE_CURRENT_CODE_HI:0] > `CCR_FAST_CHARGE_CURRENT_CODE_MAX) |-> fast_charge_current_code == `CCR_FAST_CHARGE_CURRENT_CODE_MAX)
        else $error("fast charge code not clamped");
    a_pre_clamp: assert property (precharge_current_code <= `CCR_IPRE_MAX) // R16
        else $error("precharge code above clamp");
    a_switch_size: assert property ( // R10
        $past(!sys_ctl[`CCR_BIT_BOOST] && !cur_ctl[`CCR_BIT_FULL]
        && input_current_limit_code < `CCR_IIN_700MA) |-> !input_switch_full_size)
        else $error("full switch used below 700 mA");
    a_boost_full_fet: assert property ($past(sys_ctl[`CCR_BIT_BOOST]) |-> input_switch_full_size) // R11
        else $error("boost without full input switch");
    a_wdog_keeps: assert property ( // R17
        watchdog_expired && !reg_reset && !wr_stb |=>
        ((sys_ctl & `CCR_WDK_SYS) == ($past(sys_ctl) & `CCR_WDK_SYS))
        && ((cur_ctl & ~`CCR_WDK_CUR) == (`CCR_RST_CUR & ~`CCR_WDK_CUR)))
        else $error("watchdog restore wrong");

    c_reg_write: cover property (wr_stb && wr_idx == `CCR_OFS_CUR);
    c_read_byte: cover property (state == CCR_RDATA ##[1:400] state == CCR_RDATA_ACK);
    c_wdog_restore: cover property (watchdog_expired ##1 !sys_ctl[`CCR_BIT_BOOST]);
    c_charge_on: cover property (charge_allowed);
endmodule

//--- logic/ccr_field_decode.sv
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_field_decode
    import ccr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    ccr_cfg_if.dec cfg
);
    logic [5:0] fast_charge_current_code_raw;
    logic [3:0] pre_raw;

    assign fast_charge_current_code_raw = cfg.cur_ctl[`CCR_FAST_CHARGE_CURRENT_CODE_HI:0];
    assign pre_raw = cfg.pre_term[`CCR_PRE_HI:`CCR_PRE_LO];

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cfg.charge_run <= 1'b0;
            cfg.switch_low <= 1'b0;
            cfg.fast_charge_current_code_eff <= 6'h00;
            cfg.pre_eff <= 4'h0;
        end
        else
        begin
            cfg.charge_run <= !cfg.ce_n_s && cfg.sys_ctl[`CCR_BIT_CHG] // R5
                && !cfg.sys_ctl[`CCR_BIT_BOOST] // R4
                && (fast_charge_current_code_raw != 6'h00); // R13
            cfg.switch_low <= cfg.sys_ctl[`CCR_BIT_BOOST] // R11
                || cfg.cur_ctl[`CCR_BIT_FULL] || (cfg.iin_code >= `CCR_IIN_700MA); // R10
            cfg.fast_charge_current_code_eff <= (fast_charge_current_code_raw > `CCR_FAST_CHARGE_CURRENT_CODE_MAX) ? `CCR_FAST_CHARGE_CURRENT_CODE_MAX : fast_charge_current_code_raw; // R14
            cfg.pre_eff <= (pre_raw > `CCR_IPRE_MAX) ? `CCR_IPRE_MAX : pre_raw; // R16
        end
    end
endmodule

//--- logic/ccr_sync2.sv
`timescale 1ns/100ps
module ccr_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // idle-high reset keeps a released bus from looking like a start
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

//--- sim/ccr_host_model.sv
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_host_model (
    input wire logic sys_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic host_low;
    // open-drain data line with pull-up: low while either side pulls
    assign sda = !(host_low || sda_oe);
    initial
    begin
        scl = 1'b1;
        host_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // data moves one clock after scl falls, so no false start or stop is seen
    task automatic bit_io(input logic low, output logic v);
        tick(1);
        host_low <= low;
        tick(4);
        scl <= 1'b1;
        tick(4);
        #1 v = sda;
        tick(1);
        scl <= 1'b0;
    endtask
    task automatic start_c();
        tick(1);
        host_low <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(5);
        host_low <= 1'b1;
        tick(5);
        scl <= 1'b0;
    endtask
    task automatic stop_c();
        tick(1);
        host_low <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(5);
        host_low <= 1'b0;
        tick(5);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--)
            bit_io(!b[i], v);
        bit_io(1'b0, v);
        ack = !v;
    endtask
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_c();
        put_byte({`CCR_DEV_ADDR, 1'b0}, a0);
        put_byte(ptr, a1);
        put_byte(d, a2);
        stop_c();
        ok = a0 && a1 && a2;
    endtask
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic a0, a1, a2, v;
        start_c();
        put_byte({`CCR_DEV_ADDR, 1'b0}, a0);
        put_byte(ptr, a1);
        start_c();
        put_byte({`CCR_DEV_ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b0, v);
            d[i] = v;
        end
        bit_io(1'b0, v);
        stop_c();
        ok = a0 && a1 && a2;
    endtask
    // two bytes in one read: ack the first, nack the second
    task automatic read_pair(input logic [7:0] ptr, output logic [15:0] d, output logic ok);
        logic a0, a1, a2, v;
        start_c();
        put_byte({`CCR_DEV_ADDR, 1'b0}, a0);
        put_byte(ptr, a1);
        start_c();
        put_byte({`CCR_DEV_ADDR, 1'b1}, a2);
        for (int i = 15; i >= 0; i--)
        begin
            bit_io(1'b0, v);
            d[i] = v;
            if (i == 8)
                bit_io(1'b1, v);
        end
        bit_io(1'b0, v);
        stop_c();
        ok = a0 && a1 && a2;
    endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/100ps
`include "ccr_params.svh"
module tb;
    logic sys_clk, rst, scl, sda, sda_out, sda_oe, charge_enable_n, reg_reset, watchdog_expired;
    logic pulse_skip_disable, watchdog_kick, boost_enable, charge_allowed, boost_floor_low_sel;
    logic boost_current_limit, input_switch_full_size;
    logic [4:0] iin;
    logic [2:0] system_floor_voltage;
    logic [5:0] fast_charge_current_code;
    logic [3:0] precharge_current_code, termination_current_code;
    logic [5:0] ich_in [5] = '{6'h00, 6'h01, 6'h32, 6'h33, 6'h3F};
    logic [5:0] ich_exp [5] = '{6'h00, 6'h01, 6'h32, 6'h32, 6'h32};
    int err_count, compares, kicks, k0;
    logic [15:0] pair;
    logic pair_ok;
    ccr_charger_regs i_dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .charge_enable_n(charge_enable_n),
        .reg_reset(reg_reset),
        .watchdog_expired(watchdog_expired),
        .input_current_limit_code(iin),
        .pulse_skip_disable(pulse_skip_disable),
        .watchdog_kick(watchdog_kick),
        .boost_enable(boost_enable),
        .charge_allowed(charge_allowed),
        .system_floor_voltage(system_floor_voltage),
        .boost_floor_low_sel(boost_floor_low_sel),
        .boost_current_limit(boost_current_limit),
        .input_switch_full_size(input_switch_full_size),
        .fast_charge_current_code(fast_charge_current_code),
        .precharge_current_code(precharge_current_code),
        .termination_current_code(termination_current_code)
    );
    ccr_host_model i_host (
        .sys_clk(sys_clk),
        .sda_oe(sda_oe),
        .scl(scl),
        .sda(sda)
    );
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (watchdog_kick === 1'b1)
            kicks <= kicks + 1;
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input logic ack_exp);
        logic ok;
        i_host.write_reg(ptr, d, ok);
        chk({7'h00, ok}, {7'h00, ack_exp}, "write ack");
    endtask
    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp, input logic ack_exp);
        logic ok;
        logic [7:0] d;
        i_host.read_reg(ptr, d, ok);
        chk({7'h00, ok}, {7'h00, ack_exp}, "read ack");
        if (ack_exp)
            chk(d, exp, "read data");
    endtask
    task automatic sz(input logic [4:0] code, input logic exp);
        iin <= code;
        wait_n(4);
        chk({7'h00, input_switch_full_size}, {7'h00, exp}, "switch size");
    endtask
    task automatic pulse(input int which);
        if (which == 0)
            watchdog_expired <= 1'b1;
        else
            reg_reset <= 1'b1;
        wait_n(1);
        watchdog_expired <= 1'b0;
        reg_reset <= 1'b0;
        wait_n(3);
    endtask
    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #3_000_000;
        err_count++;
        $display("BAD at %0t: run timed out", $time);
        close_out();
    end
    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        charge_enable_n = 1'b0;
        reg_reset = 1'b0;
        watchdog_expired = 1'b0;
        iin = 5'h00;
        err_count = 0;
        compares = 0;
        kicks = 0;
        wait_n(5);
        rst <= 1'b0;
        wait_n(4);
        rd(`CCR_OFS_SYS, 8'h1A, 1'b1);
        rd(`CCR_OFS_CUR, 8'hA2, 1'b1);
        rd(`CCR_OFS_PRE, 8'h22, 1'b1);
        i_host.read_pair(`CCR_OFS_SYS, pair, pair_ok);
        chk({7'h00, pair_ok}, 8'h01, "pair ack");
        chk(pair[15:8], 8'h1A, "pair first");
        chk(pair[7:0], 8'hA2, "pair second");
        chk({7'h00, sda_out}, 8'h00, "sda out level");
        chk({1'b0, pulse_skip_disable, boost_enable, charge_allowed, system_floor_voltage,
            boost_floor_low_sel}, 8'h1A, "sys outs");
        chk({boost_current_limit, input_switch_full_size, fast_charge_current_code}, 8'hA2,
            "cur outs");
        chk({precharge_current_code, termination_current_code}, 8'h22, "pre outs");
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            wr(`CCR_OFS_SYS, {i[0], 3'b001, i[2:0], !i[0]}, 1'b1);
            chk({3'b000, pulse_skip_disable, system_floor_voltage, boost_floor_low_sel},
                {3'b000, i[0], i[2:0], !i[0]}, "floor outs");
            rd(`CCR_OFS_SYS, {i[0], 3'b001, i[2:0], !i[0]}, 1'b1);
        end
        $display("test floor done");
        k0 = kicks;
        wr(`CCR_OFS_SYS, 8'h5A, 1'b1);
        chk(8'(kicks - k0), 8'h01, "kick pulses");
        rd(`CCR_OFS_SYS, 8'h1A, 1'b1);
        $display("test kick done");
        wr(`CCR_OFS_SYS, 8'h3A, 1'b1);
        chk({5'h00, boost_enable, charge_allowed, input_switch_full_size}, 8'h05, "boost");
        wr(`CCR_OFS_SYS, 8'h0A, 1'b1);
        chk({7'h00, charge_allowed}, 8'h00, "charge bit off");
        wr(`CCR_OFS_SYS, 8'h1A, 1'b1);
        charge_enable_n <= 1'b1;
        wait_n(5);
        chk({7'h00, charge_allowed}, 8'h00, "pin high");
        charge_enable_n <= 1'b0;
        wait_n(5);
        chk({7'h00, charge_allowed}, 8'h01, "pin low");
        $display("test charge gate done");
        for (int i = 0; i < 5; i++)
        begin
            wr(`CCR_OFS_CUR, {i[0], 1'b0, ich_in[i]}, 1'b1);
            chk({boost_current_limit, 1'b0, fast_charge_current_code}, {i[0], 1'b0, ich_exp[i]},
                "cur outs");
            chk({7'h00, charge_allowed}, {7'h00, ich_exp[i] != 6'h00}, "zero code");
        end
        rd(`CCR_OFS_CUR, 8'h3F, 1'b1);
        $display("test fast charge done");
        sz(5'h05, 1'b0);
        sz(5'h06, 1'b1);
        wr(`CCR_OFS_CUR, 8'h62, 1'b1);
        sz(5'h00, 1'b1);
        $display("test switch done");
        wr(`CCR_OFS_PRE, 8'hD5, 1'b1);
        chk({precharge_current_code, termination_current_code}, 8'hC5, "pre clamp");
        wr(`CCR_OFS_PRE, 8'hB7, 1'b1);
        chk({precharge_current_code, termination_current_code}, 8'hB7, "pre fields");
        rd(`CCR_OFS_PRE, 8'hB7, 1'b1);
        $display("test precharge done");
        // expiry keeps skip, floor, threshold and sizing bits only
        wr(`CCR_OFS_SYS, 8'hBF, 1'b1);
        pulse(0);
        rd(`CCR_OFS_SYS, 8'h9F, 1'b1);
        rd(`CCR_OFS_CUR, 8'hE2, 1'b1);
        rd(`CCR_OFS_PRE, 8'h22, 1'b1);
        pulse(1);
        rd(`CCR_OFS_SYS, 8'h1A, 1'b1);
        rd(`CCR_OFS_CUR, 8'hA2, 1'b1);
        $display("test watchdog and register reset done");
        wr(8'h04, 8'h00, 1'b0);
        rd(8'h00, 8'h00, 1'b0);
        rd(`CCR_OFS_SYS, 8'h1A, 1'b1);
        $display("test refusals done");
        close_out();
    end
endmodule
